/* core/tbx_gap_timer.sv */
// gap timer that paces 10 mb driver test sequences
`timescale 1ns/1ps
module tbx_gap_timer #(
    parameter int SHORT_CYC = tbx_pkg::GAP_SHORT_CYC,
    parameter int LONG_CYC  = tbx_pkg::GAP_LONG_CYC
) (
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    input  wire logic i_run,
    input  wire logic i_long_gap,
    output logic      o_gap_done
);

    localparam int CW = $clog2(LONG_CYC + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          done_q;
    wire  [CW-1:0] limit_w = i_long_gap ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
    wire           hit_w   = i_run && (cnt_q >= limit_w);

    assign cnt_d = (!i_run || hit_w) ? '0 : cnt_q + CW'(1);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= hit_w;
        end
    end

    assign o_gap_done = done_q;

endmodule : tbx_gap_timer

/* core/tbx_regs.sv */
// 10base-t status/control and driver-test/self-test extension registers
//
// Operation
// RULE1: three-bit squelch field sets squelch threshold, reset 100
// RULE2: wrap-off bit ORed with basic control loopback
// RULE3: link pulse disable stops normal link pulses
// RULE4: force-link bit ORed with host force input
// RULE5: force bit treats receive polarity as inverted
// RULE6: polarity status mirrored; either read clears both
// RULE7: disable bit stops automatic polarity correction
// RULE8: scale msb plus detect bit selects silence
// RULE9: heartbeat bit acts only in 10 half-duplex
// RULE10: jabber disable bit affects only 10base-t
// RULE11: eight-bit read-only self-test nibble error counter
// RULE12: error counter cleared when self-test restarts
// RULE13: error counter saturates at FF, never wraps
// RULE14: mii clock bit forces tx/rx clocks on
// RULE15: gapless bit plus self-test gives continuous data
// RULE16: software sets jabber disable before 10 continuous
// RULE17: pattern enable makes driver send test pattern
// RULE18: pull-up follows bit; cleared on hard reset only
// RULE19: software keeps pull-up off on shared bus
// RULE20: gap bit selects 15 us or 10 us
// RULE21: top bit reads zero; reserved fields written zero
// RULE22: two-bit select picks driver test pattern
// RULE23: polarity status holds one until read
`timescale 1ns/1ps
module tbx_regs (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic        i_soft_reset,
    // management register port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    // device context
    input  wire logic        i_basic_ctrl_loopback,
    input  wire logic        i_host_link_force_input,
    input  wire logic        i_sd_cfg_bit10,
    input  wire logic        i_speed_100,
    input  wire logic        i_full_duplex,
    input  wire logic        i_rmii_slave,
    input  wire logic        i_main_status_read,
    input  wire logic        i_inversion_seen,
    input  wire logic        i_selftest_enable,
    input  wire logic        i_selftest_restart,
    input  wire logic        i_nibble_error,
    // controls out
    output logic [2:0]       o_squelch_sel,
    output logic             o_ten_meg_wrap_off,
    output logic             o_link_pulse_tx_off,
    output logic             o_forced_link_good,
    output logic             o_inversion_force,
    output logic             o_polarity_status,
    output logic             o_auto_inversion_fix_off,
    output logic [1:0]       o_silence_threshold_sel,
    output logic             o_sqe_test_on,
    output logic             o_long_tx_guard_on,
    output logic             o_mii_clocks_on,
    output logic             o_selftest_gapless_tx,
    output logic             o_driver_pattern_on,
    output logic [1:0]       o_driver_pattern_select,
    output logic             o_test_sequence_start,
    output logic             o_mgmt_line_pullup_on
);

    // ****************************************
    // state
    // ****************************************
    tbx_pkg::tbx_ctl_t ctl_q;
    tbx_pkg::tbx_ctl_t ctl_d;
    tbx_pkg::tbx_ext_t ext_q;
    tbx_pkg::tbx_ext_t ext_d;
    logic              pullup_q;
    logic              pol_q;
    logic [7:0]        errcnt_q;
    logic [7:0]        errcnt_d;
    logic [15:0]       rdata_q;
    logic [2:0]        pin_sync_q;
    logic              force_in_q;
    logic [17:5]       out_q;
    logic [1:0]        sil_q;
    logic [2:0]        squelch_q;
    logic [1:0]        psel_q;
    logic              seq_start_w;

    // ****************************************
    // decode
    // ****************************************
    wire sel_ctl_w  = (i_reg_addr == tbx_pkg::OFS_TENBASE_T_STATUS_CONTROL);
    wire sel_ext_w  = (i_reg_addr == tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION);
    wire wr_ctl_w   = i_reg_wr && sel_ctl_w;
    wire wr_ext_w   = i_reg_wr && sel_ext_w;
    wire rd_ctl_w   = i_reg_rd && sel_ctl_w;
    wire any_rst_w  = i_reset || i_soft_reset;

    // top bit is never stored, so it cannot read back as one
    wire [15:0] ctl_view_w = {1'b0, ctl_q.rsv, ctl_q.squelch, ctl_q.wrap_off, ctl_q.lp_off,
                              ctl_q.force_link, ctl_q.inv_force, pol_q, ctl_q.auto_fix_off,
                              ctl_q.sil_msb, ctl_q.sqe_off, ctl_q.guard_off}; // RULE21
    wire [15:0] ext_view_w = {errcnt_q, ext_q.rsv, ext_q.mii_clk_on, ext_q.gapless,
                              ext_q.patt_on, pullup_q, ext_q.gap_long, ext_q.patt_sel};
    wire [15:0] rd_mux_w   = sel_ctl_w ? ctl_view_w : (sel_ext_w ? ext_view_w : 16'h0000);

    assign ctl_d = wr_ctl_w ? tbx_pkg::tbx_ctl_t'({
                       i_reg_wdata[tbx_pkg::TB_RSV_HI:tbx_pkg::TB_RSV_LO],
                       i_reg_wdata[tbx_pkg::TB_SQUELCH_HI:tbx_pkg::TB_SQUELCH_LO],
                       i_reg_wdata[tbx_pkg::TB_WRAP_OFF_BIT:tbx_pkg::TB_INV_FORCE_BIT],
                       i_reg_wdata[tbx_pkg::TB_AUTO_FIX_BIT:tbx_pkg::TB_GUARD_OFF_BIT]})
                   : ctl_q; // RULE21 RULE1

    assign ext_d = wr_ext_w ? tbx_pkg::tbx_ext_t'({
                       i_reg_wdata[tbx_pkg::DT_RSV_BIT:tbx_pkg::DT_PATT_ON_BIT],
                       i_reg_wdata[tbx_pkg::DT_GAP_SEL_BIT:tbx_pkg::DT_PATT_SEL_LO]})
                   : ext_q;

    // restart wins over a counted error in the same cycle
    assign errcnt_d = i_selftest_restart ? 8'h00 :                                  // RULE12
                      (i_nibble_error && errcnt_q != tbx_pkg::ERRCNT_MAX)           // RULE13
                      ? errcnt_q + 8'h01 : errcnt_q;                                // RULE11

    // ****************************************
    // register storage
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (any_rst_w) begin
            ctl_q         <= '0;
            ctl_q.squelch <= tbx_pkg::RST_SQUELCH;     // RULE1
            ctl_q.sil_msb <= tbx_pkg::RST_SIL_MSB;     // RULE8
            ext_q         <= '0;
        end else begin
            ctl_q <= ctl_d;
            ext_q <= ext_d;
        end
    end

    // pull-up survives soft reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pullup_q <= 1'b0;                          // RULE18
        end else if (wr_ext_w) begin
            pullup_q <= i_reg_wdata[tbx_pkg::DT_PULLUP_BIT];
        end
    end

    // set wins over a clear from either register read
    always_ff @(posedge i_core_clk) begin
        if (any_rst_w) begin
            pol_q <= 1'b0;
        end else if (i_inversion_seen) begin
            pol_q <= 1'b1;                             // RULE23
        end else if (rd_ctl_w || i_main_status_read) begin
            pol_q <= 1'b0;                             // RULE6
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (any_rst_w) begin
            errcnt_q <= 8'h00;
            rdata_q  <= 16'h0000;
        end else begin
            errcnt_q <= errcnt_d;
            if (i_reg_rd) begin
                rdata_q <= rd_mux_w;
            end
        end
    end

    // ****************************************
    // pin synchroniser for the host force input
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pin_sync_q <= 3'h0;
            force_in_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], i_host_link_force_input};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                force_in_q <= pin_sync_q[2];
            end
        end
    end

    // ****************************************
    // test sequence pacing
    // ****************************************
    tbx_gap_timer #(
        .SHORT_CYC (tbx_pkg::GAP_SHORT_CYC),
        .LONG_CYC  (tbx_pkg::GAP_LONG_CYC)
    ) u_gap (
        .i_core_clk (i_core_clk),
        .i_reset    (any_rst_w),
        .i_run      (ext_q.patt_on),
        .i_long_gap (ext_q.gap_long),                  // RULE20
        .o_gap_done (seq_start_w)
    );

    // ****************************************
    // control outputs
    // ****************************************
    wire wrap_off_w  = ctl_q.wrap_off | i_basic_ctrl_loopback;                   // RULE2
    wire lp_off_w    = ctl_q.lp_off;                                             // RULE3
    wire link_good_w = ctl_q.force_link | force_in_q;                            // RULE4
    wire inv_w       = ctl_q.inv_force;                                          // RULE5
    wire fix_off_w   = ctl_q.auto_fix_off;                                       // RULE7
    wire sqe_w       = !i_speed_100 && !i_full_duplex && !ctl_q.sqe_off;         // RULE9
    wire guard_w     = !i_speed_100 && !ctl_q.guard_off;                         // RULE10
    wire mii_w       = ext_q.mii_clk_on | !i_rmii_slave;                         // RULE14
    wire gapless_w   = ext_q.gapless & i_selftest_enable;                        // RULE15
    wire patt_w      = ext_q.patt_on;                                            // RULE17

    // outputs leave from flops, so each control lags its bit by one cycle
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            out_q     <= '0;
            sil_q     <= 2'b00;
            squelch_q <= tbx_pkg::RST_SQUELCH;
            psel_q    <= 2'b00;
        end else begin
            out_q     <= {wrap_off_w, lp_off_w, link_good_w, inv_w, pol_q, fix_off_w,
                          sqe_w, guard_w, mii_w, gapless_w, patt_w, seq_start_w,
                          pullup_q};
            sil_q     <= {ctl_q.sil_msb, i_sd_cfg_bit10};                       // RULE8
            squelch_q <= ctl_q.squelch;                                          // RULE1
            psel_q    <= patt_w ? ext_q.patt_sel : 2'b00;                        // RULE22
        end
    end

    assign o_reg_rdata              = rdata_q;
    assign o_squelch_sel            = squelch_q;
    assign o_ten_meg_wrap_off       = out_q[17];
    assign o_link_pulse_tx_off      = out_q[16];
    assign o_forced_link_good       = out_q[15];
    assign o_inversion_force        = out_q[14];
    assign o_polarity_status        = out_q[13];
    assign o_auto_inversion_fix_off = out_q[12];
    assign o_silence_threshold_sel  = sil_q;
    assign o_sqe_test_on            = out_q[11];
    assign o_long_tx_guard_on       = out_q[10];
    assign o_mii_clocks_on          = out_q[9];
    assign o_selftest_gapless_tx    = out_q[8];
    assign o_driver_pattern_on      = out_q[7];
    assign o_driver_pattern_select  = psel_q;
    assign o_test_sequence_start    = out_q[6];
    assign o_mgmt_line_pullup_on    = out_q[5];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_ctl_write;
        wr_ctl_w && !i_soft_reset;
    endsequence

    sequence s_ctl_read_back;
        rd_ctl_w && !any_rst_w;
    endsequence

    squelch_field_a: assert property (s_ctl_write ##1 !any_rst_w |-> ##1                  // RULE1
        o_squelch_sel == $past(i_reg_wdata[tbx_pkg::TB_SQUELCH_HI:tbx_pkg::TB_SQUELCH_LO], 2))
        else $error("squelch output does not follow written field");

    top_bit_zero_a: assert property (s_ctl_read_back |=> o_reg_rdata[15] == 1'b0)          // RULE21
        else $error("top reserved bit read back as one");

    wrap_or_a: assert property (!i_reset |=> o_ten_meg_wrap_off ==                         // RULE2
        ($past(ctl_q.wrap_off) | $past(i_basic_ctrl_loopback)))
        else $error("wrap-off output is not the or of both sources");

    pol_hold_a: assert property (pol_q && !i_main_status_read && !rd_ctl_w && !any_rst_w   // RULE23
        |=> pol_q)
        else $error("polarity status dropped without a read");

    pol_set_wins_a: assert property (i_inversion_seen && !any_rst_w |=> pol_q ##1          // RULE6
        o_polarity_status)
        else $error("polarity event lost against a clear");

    err_sat_a: assert property (errcnt_q == tbx_pkg::ERRCNT_MAX && !i_selftest_restart    // RULE13
        && !any_rst_w |=> errcnt_q == tbx_pkg::ERRCNT_MAX)
        else $error("error counter left its maximum");

    err_restart_a: assert property (i_selftest_restart && !any_rst_w |=> errcnt_q == 8'h00) // RULE12
        else $error("error counter not cleared on restart");

    err_count_a: assert property (i_nibble_error && !i_selftest_restart && !any_rst_w      // RULE11
        && errcnt_q != tbx_pkg::ERRCNT_MAX |=> errcnt_q == $past(errcnt_q) + 8'h01)
        else $error("errored nibble not counted");

    sqe_gate_a: assert property (i_speed_100 || i_full_duplex |=> !o_sqe_test_on)          // RULE9
        else $error("heartbeat active outside 10 half duplex");

    guard_gate_a: assert property (i_speed_100 |=> !o_long_tx_guard_on)                   // RULE10
        else $error("jabber guard active at 100");

    pullup_keep_a: assert property (i_soft_reset && !i_reset && !wr_ext_w |=>              // RULE18
        pullup_q == $past(pullup_q))
        else $error("pull-up enable lost on soft reset");

    mii_force_a: assert property (ext_q.mii_clk_on |=> o_mii_clocks_on)                   // RULE14
        else $error("mii clocks not forced on");

endmodule : tbx_regs

/* pkg/tbx_pkg.sv */
// package: register map, field layout, reset values and timing of the 10base-t/self-test bank
package tbx_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [4:0] OFS_TENBASE_T_STATUS_CONTROL       = 5'h1A;
    localparam logic [4:0] OFS_DRIVER_TEST_SELFTEST_EXTENSION = 5'h1B;

    // ****************************************
    // field positions, tenbase_t_status_control
    // ****************************************
    localparam int TB_RSV_TOP_BIT   = 15;
    localparam int TB_RSV_HI        = 14;
    localparam int TB_RSV_LO        = 12;
    localparam int TB_SQUELCH_HI    = 11;
    localparam int TB_SQUELCH_LO    = 9;
    localparam int TB_WRAP_OFF_BIT  = 8;
    localparam int TB_LP_OFF_BIT    = 7;
    localparam int TB_FORCE_LNK_BIT = 6;
    localparam int TB_INV_FORCE_BIT = 5;
    localparam int TB_POLARITY_BIT  = 4;
    localparam int TB_AUTO_FIX_BIT  = 3;
    localparam int TB_SIL_MSB_BIT   = 2;
    localparam int TB_SQE_OFF_BIT   = 1;
    localparam int TB_GUARD_OFF_BIT = 0;

    // ****************************************
    // field positions, driver_test_selftest_extension
    // ****************************************
    localparam int DT_ERRCNT_HI     = 15;
    localparam int DT_ERRCNT_LO     = 8;
    localparam int DT_RSV_BIT       = 7;
    localparam int DT_MII_CLK_BIT   = 6;
    localparam int DT_GAPLESS_BIT   = 5;
    localparam int DT_PATT_ON_BIT   = 4;
    localparam int DT_PULLUP_BIT    = 3;
    localparam int DT_GAP_SEL_BIT   = 2;
    localparam int DT_PATT_SEL_HI   = 1;
    localparam int DT_PATT_SEL_LO   = 0;

    // ****************************************
    // reset values and error counter limit
    // ****************************************
    localparam logic [2:0] RST_SQUELCH   = 3'h4;
    localparam logic       RST_SIL_MSB   = 1'b1;
    localparam logic [7:0] ERRCNT_MAX    = 8'hFF;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 4;
    localparam int GAP_SHORT_NS   = 10000;
    localparam int GAP_LONG_NS    = 15000;
    localparam int GAP_SHORT_CYC  = GAP_SHORT_NS / CLK_PERIOD_NS;
    localparam int GAP_LONG_CYC   = GAP_LONG_NS / CLK_PERIOD_NS;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        TBX_PATT_DATA_EOP0 = 2'b00,
        TBX_PATT_DATA_EOP1 = 2'b01,
        TBX_PATT_LINK_PLS  = 2'b10,
        TBX_PATT_MAN_ONES  = 2'b11
    } tbx_patt_t;

    typedef struct packed {
        logic [2:0] rsv;
        logic [2:0] squelch;
        logic       wrap_off;
        logic       lp_off;
        logic       force_link;
        logic       inv_force;
        logic       auto_fix_off;
        logic       sil_msb;
        logic       sqe_off;
        logic       guard_off;
    } tbx_ctl_t;

    typedef struct packed {
        logic       rsv;
        logic       mii_clk_on;
        logic       gapless;
        logic       patt_on;
        logic       gap_long;
        tbx_patt_t  patt_sel;
    } tbx_ext_t;

endpackage : tbx_pkg

/* verification/test_tbx_regs.sv */
// self-checking bench for the 10base-t and driver-test/self-test register bank
`timescale 1ns/1ps
module test_tbx_regs;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        i_core_clk, i_reset, i_soft_reset, i_reg_wr, i_reg_rd;
    logic [4:0]  i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, rv;
    logic        i_basic_ctrl_loopback, i_host_link_force_input, i_sd_cfg_bit10;
    logic        i_speed_100, i_full_duplex, i_rmii_slave, i_main_status_read;
    logic        i_inversion_seen, i_selftest_enable, i_selftest_restart, i_nibble_error;
    logic [2:0]  o_squelch_sel;
    logic [1:0]  o_silence_threshold_sel, o_driver_pattern_select;
    logic        o_ten_meg_wrap_off, o_link_pulse_tx_off, o_forced_link_good;
    logic        o_inversion_force, o_polarity_status, o_auto_inversion_fix_off;
    logic        o_sqe_test_on, o_long_tx_guard_on, o_mii_clocks_on, o_selftest_gapless_tx;
    logic        o_driver_pattern_on, o_test_sequence_start, o_mgmt_line_pullup_on;
    int          n_fail, checks_done, gap;

    tbx_regs tbx_regs_i (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_soft_reset(i_soft_reset),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_basic_ctrl_loopback(i_basic_ctrl_loopback),
        .i_host_link_force_input(i_host_link_force_input),
        .i_sd_cfg_bit10(i_sd_cfg_bit10), .i_speed_100(i_speed_100),
        .i_full_duplex(i_full_duplex), .i_rmii_slave(i_rmii_slave),
        .i_main_status_read(i_main_status_read), .i_inversion_seen(i_inversion_seen),
        .i_selftest_enable(i_selftest_enable), .i_selftest_restart(i_selftest_restart),
        .i_nibble_error(i_nibble_error), .o_squelch_sel(o_squelch_sel),
        .o_ten_meg_wrap_off(o_ten_meg_wrap_off), .o_link_pulse_tx_off(o_link_pulse_tx_off),
        .o_forced_link_good(o_forced_link_good), .o_inversion_force(o_inversion_force),
        .o_polarity_status(o_polarity_status),
        .o_auto_inversion_fix_off(o_auto_inversion_fix_off),
        .o_silence_threshold_sel(o_silence_threshold_sel), .o_sqe_test_on(o_sqe_test_on),
        .o_long_tx_guard_on(o_long_tx_guard_on), .o_mii_clocks_on(o_mii_clocks_on),
        .o_selftest_gapless_tx(o_selftest_gapless_tx),
        .o_driver_pattern_on(o_driver_pattern_on),
        .o_driver_pattern_select(o_driver_pattern_select),
        .o_test_sequence_start(o_test_sequence_start),
        .o_mgmt_line_pullup_on(o_mgmt_line_pullup_on)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic settle;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask : settle

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
        settle();
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_core_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_core_clk);
        #1;
        d = o_reg_rdata;
    endtask : rd

    // holds a strobe high for n sampling edges
    task automatic strobe(input int which, input int n);
        @(posedge i_core_clk);
        case (which)
            0: i_inversion_seen <= 1'b1;
            1: i_main_status_read <= 1'b1;
            2: i_selftest_restart <= 1'b1;
            default: i_nibble_error <= 1'b1;
        endcase
        repeat (n) @(posedge i_core_clk);
        {i_inversion_seen, i_main_status_read, i_selftest_restart, i_nibble_error} <= 4'h0;
        settle();
    endtask : strobe

    // counts edges up to the next sequence start; a hang counts as a mismatch
    task automatic next_start(output int n);
        n = 0;
        do begin
            @(posedge i_core_clk);
            #1;
            n++;
        end while (o_test_sequence_start !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            n_fail++;
            $display("[FAIL] sequence start wait timed out");
            close_out();
        end
    endtask : next_start

    task automatic hard_reset;
        @(posedge i_core_clk);
        i_reset <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        i_reset <= 1'b0;
        settle();
    endtask : hard_reset

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        n_fail = 0;
        checks_done = 0;
        {i_reset, i_soft_reset, i_reg_wr, i_reg_rd} = 4'h8;
        i_reg_addr = 5'h00;
        i_reg_wdata = 16'h0000;
        {i_basic_ctrl_loopback, i_host_link_force_input, i_sd_cfg_bit10} = 3'h0;
        {i_speed_100, i_full_duplex, i_rmii_slave, i_main_status_read} = 4'h0;
        {i_inversion_seen, i_selftest_enable, i_selftest_restart, i_nibble_error} = 4'h0;
        hard_reset();
        rd(tbx_pkg::OFS_TENBASE_T_STATUS_CONTROL, rv);
        check("ctl reset", rv, 16'h0804);
        rd(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, rv);
        check("ext reset", rv, 16'h0000);
        check("squelch reset", o_squelch_sel, 16'h0004);
        check("silence reset", o_silence_threshold_sel, 16'h0002);
        check("sqe on", o_sqe_test_on, 16'h0001);
        check("guard on", o_long_tx_guard_on, 16'h0001);
        check("mii clk default", o_mii_clocks_on, 16'h0001);
        wr(tbx_pkg::OFS_TENBASE_T_STATUS_CONTROL, 16'h8FFF);
        rd(tbx_pkg::OFS_TENBASE_T_STATUS_CONTROL, rv);
        check("ctl all ones", rv, 16'h0FEF);
        check("squelch", o_squelch_sel, 16'h0007);
        check("wrap off", o_ten_meg_wrap_off, 16'h0001);
        check("lp off", o_link_pulse_tx_off, 16'h0001);
        check("link bit", o_forced_link_good, 16'h0001);
        check("inv force", o_inversion_force, 16'h0001);
        check("auto fix off", o_auto_inversion_fix_off, 16'h0001);
        check("sqe gated", o_sqe_test_on, 16'h0000);
        check("guard gated", o_long_tx_guard_on, 16'h0000);
        wr(tbx_pkg::OFS_TENBASE_T_STATUS_CONTROL, 16'h0000);
        i_basic_ctrl_loopback <= 1'b1;
        i_sd_cfg_bit10 <= 1'b1;
        i_speed_100 <= 1'b1;
        settle();
        check("wrap or", o_ten_meg_wrap_off, 16'h0001);
        check("silence sel", o_silence_threshold_sel, 16'h0001);
        check("sqe at 100", o_sqe_test_on, 16'h0000);
        check("guard at 100", o_long_tx_guard_on, 16'h0000);
        check("link bit clear", o_forced_link_good, 16'h0000);
        i_speed_100 <= 1'b0;
        i_full_duplex <= 1'b1;
        i_host_link_force_input <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        #1;
        check("sqe full duplex", o_sqe_test_on, 16'h0000);
        check("guard at 10", o_long_tx_guard_on, 16'h0001);
        check("link pin", o_forced_link_good, 16'h0001);
        strobe(0, 1);
        repeat (20) @(posedge i_core_clk);
        #1;
        check("polarity held", o_polarity_status, 16'h0001);
        rd(tbx_pkg::OFS_TENBASE_T_STATUS_CONTROL, rv);
        check("polarity read", rv[4], 16'h0001);
        settle();
        check("polarity cleared", o_polarity_status, 16'h0000);
        strobe(0, 1);
        strobe(1, 1);
        check("status read clear", o_polarity_status, 16'h0000);
        i_rmii_slave <= 1'b1;
        i_selftest_enable <= 1'b1;
        wr(tbx_pkg::OFS_TENBASE_T_STATUS_CONTROL, 16'h0001);
        wr(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, 16'hFF7F);
        rd(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, rv);
        check("ext all ones", rv, 16'h007F);
        check("mii clk forced", o_mii_clocks_on, 16'h0001);
        check("gapless", o_selftest_gapless_tx, 16'h0001);
        check("pattern on", o_driver_pattern_on, 16'h0001);
        check("pullup on", o_mgmt_line_pullup_on, 16'h0001);
        for (int s = 0; s < 4; s++) begin
            wr(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, 16'h0010 | 16'(s));
            check("pattern select", o_driver_pattern_select, 16'(s));
        end
        check("mii clk slave", o_mii_clocks_on, 16'h0000);
        check("gapless off", o_selftest_gapless_tx, 16'h0000);
        next_start(gap);
        next_start(gap);
        check("short gap", 16'(gap), 16'(tbx_pkg::GAP_SHORT_CYC));
        wr(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, 16'h0014);
        next_start(gap);
        next_start(gap);
        check("long gap", 16'(gap), 16'(tbx_pkg::GAP_LONG_CYC));
        wr(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, 16'h000B);
        check("select when off", o_driver_pattern_select, 16'h0000);
        check("pattern off", o_driver_pattern_on, 16'h0000);
        strobe(2, 1);
        strobe(3, 3);
        rd(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, rv);
        check("error count", rv[15:8], 16'h0003);
        strobe(3, 260);
        rd(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, rv);
        check("error saturate", rv[15:8], 16'h00FF);
        strobe(2, 1);
        rd(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, rv);
        check("error restart", rv[15:8], 16'h0000);
        // soft reset clears the bank but must leave the pull-up alone
        @(posedge i_core_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_core_clk);
        i_soft_reset <= 1'b0;
        settle();
        rd(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, rv);
        check("soft reset ext", rv, 16'h0008);
        check("pullup kept", o_mgmt_line_pullup_on, 16'h0001);
        wr(5'h1C, 16'hFFFF);
        rd(5'h1C, rv);
        check("unmapped", rv, 16'h0000);
        hard_reset();
        rd(tbx_pkg::OFS_DRIVER_TEST_SELFTEST_EXTENSION, rv);
        check("hard reset ext", rv, 16'h0000);
        check("pullup cleared", o_mgmt_line_pullup_on, 16'h0000);
        close_out();
    end
endmodule : test_tbx_regs
